// >>> tclm_top.sv
// Conversion sequencing, register file and limit alarms of the temperature monitor
//
// What this block does
// - Continuous mode restarts conversion after each 240 ms
// - Store each result; reads return latest
// - First conversion after power-up takes 6 ms
// - Default limits trip alarms above 147 and 64
// - Internal timer paces conversions, not serial clock
// - Critical and limit alarms follow setpoint comparisons
// - Configuration selects polarity of both alarms
// - Configuration selects comparator or interrupt behaviour
// - Mode 01 converts once then shuts down
// - Each rewrite of 01 runs another conversion
// - Interrupt behaviour: any read releases both alarms
// - Single-shot rewrite releases limit alarm within band
// - Single-shot rewrite releases critical alarm below band
// - Mode 10 converts 60 ms, idles 940 ms
// - Mode 11 shuts down; 00 resumes continuous
// - Leaving shutdown wakes 1 ms then converts
// - Result stays readable during shutdown
// - Fault queue of one to four consecutive faults
// - In-limit conversion clears the fault count
// - 13-bit format puts flags in bits 2:0
// - 13-bit code step is 0.0625 degrees
// - Resolution bit selects full 16-bit result
// - Ready flag low on store, high on temperature read or mode 01/10 write
// - Status flags clear on read or return
`timescale 1ns/1ps
`default_nettype none

module tclm_top #(
	parameter logic [tclm_pkg::TMR_W-1:0] P_CONV_CYC     = tclm_pkg::CONV_CYC,
	parameter logic [tclm_pkg::TMR_W-1:0] P_FAST_CYC     = tclm_pkg::FAST_CYC,
	parameter logic [tclm_pkg::TMR_W-1:0] P_SPS_CONV_CYC = tclm_pkg::SPS_CONV_CYC,
	parameter logic [tclm_pkg::TMR_W-1:0] P_SPS_IDLE_CYC = tclm_pkg::SPS_IDLE_CYC,
	parameter logic [tclm_pkg::TMR_W-1:0] P_WAKE_CYC     = tclm_pkg::WAKE_CYC
) (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	// Serial port
	input  wire logic        sclk_in,
	input  wire logic        cs_b_in,
	input  wire logic        din_in,
	output logic             dout_out,
	output logic             dout_oe_out,
	// Sensor modulator
	input  wire logic [15:0] temp_sample_in,
	output logic             modulator_en_out,
	// Alarm pins, open drain
	output logic             critical_alarm_out,
	output logic             critical_alarm_oe_out,
	output logic             limit_alarm_out,
	output logic             limit_alarm_oe_out
);

	// ==========================================================
	// State
	typedef struct packed {
		tclm_pkg::tclm_conv_e           st;
		logic [tclm_pkg::TMR_W-1:0]     tmr;
		logic [7:0]                     cfg;
		logic [7:0]                     status;
		logic [15:0]                    temp;
		logic [15:0]                    crit;
		logic [7:0]                     hyst;
		logic [15:0]                    high;
		logic [15:0]                    low;
		logic [2:0]                     fault_cnt;
		logic                           crit_act;
		logic                           lim_act;
		logic                           band_crit;
		logic                           band_lim;
		logic                           crit_pin;
		logic                           crit_oe;
		logic                           lim_pin;
		logic                           lim_oe;
		logic                           mod_en;
	} tclm_top_s;

	// Power-up: fast conversion running, alarms released (active low default)
	localparam tclm_top_s TOP_RST = '{
		st:        tclm_pkg::ST_FAST,
		tmr:       P_FAST_CYC,
		cfg:       tclm_pkg::RST_CONFIG,
		status:    tclm_pkg::RST_STATUS,
		temp:      tclm_pkg::RST_TEMP,
		crit:      tclm_pkg::RST_CRIT,
		hyst:      tclm_pkg::RST_HYST,
		high:      tclm_pkg::RST_HIGH,
		low:       tclm_pkg::RST_LOW,
		fault_cnt: 3'h0,
		crit_act:  1'b0,
		lim_act:   1'b0,
		band_crit: 1'b0,
		band_lim:  1'b0,
		crit_pin:  1'b1,
		crit_oe:   1'b0,
		lim_pin:   1'b1,
		lim_oe:    1'b0,
		mod_en:    1'b1
	};

	tclm_top_s              r;
	tclm_top_s              n;
	logic [2:0]             sp_addr;
	logic                   sp_rd;
	logic                   sp_wr;
	logic [15:0]            sp_wdata;
	logic                   addr_wide;
	logic [15:0]            rd_data;
	logic                   res16;
	logic [15:0]            mask;
	logic [15:0]            samp;
	logic signed [16:0]     t_v;
	logic signed [16:0]     crit_v;
	logic signed [16:0]     high_v;
	logic signed [16:0]     low_v;
	logic signed [16:0]     hyst_v;
	logic                   over_crit;
	logic                   over_high;
	logic                   under_low;
	logic                   fault;
	logic                   in_crit;
	logic                   in_high;
	logic                   in_low;
	logic [2:0]             need;
	logic [2:0]             cnt_nxt;
	logic                   qual;
	logic                   conv_done;
	logic                   int_mode;
	logic                   mode_wr;
	tclm_pkg::tclm_mode_e   cur_mode;
	tclm_pkg::tclm_mode_e   wr_mode;
	logic [2:0]             flags;

	// ==========================================================
	// Serial port
	tclm_spi u_spi (
		.mclk_in       (mclk_in),
		.rst_b_in      (rst_b_in),
		.sclk_in       (sclk_in),
		.cs_b_in       (cs_b_in),
		.din_in        (din_in),
		.dout_out      (dout_out),
		.dout_oe_out   (dout_oe_out),
		.addr_wide_in  (addr_wide),
		.rd_data_in    (rd_data),
		.addr_out      (sp_addr),
		.rd_strobe_out (sp_rd),
		.wr_strobe_out (sp_wr),
		.wr_data_out   (sp_wdata)
	);

	assign addr_wide = (sp_addr == tclm_pkg::ADDR_TEMP) || (sp_addr == tclm_pkg::ADDR_CRIT) ||
		(sp_addr == tclm_pkg::ADDR_HIGH) || (sp_addr == tclm_pkg::ADDR_LOW);

	// Read mux; status and ID have no writable state behind them
	function automatic logic [15:0] read_reg(input logic [2:0] a, input tclm_top_s s);
		case (a)
			tclm_pkg::ADDR_STATUS: read_reg = {8'h00, s.status};
			tclm_pkg::ADDR_CONFIG: read_reg = {8'h00, s.cfg};
			tclm_pkg::ADDR_TEMP:   read_reg = s.temp;
			tclm_pkg::ADDR_ID:     read_reg = {8'h00, tclm_pkg::ID_VALUE};
			tclm_pkg::ADDR_CRIT:   read_reg = s.crit;
			tclm_pkg::ADDR_HYST:   read_reg = {8'h00, s.hyst};
			tclm_pkg::ADDR_HIGH:   read_reg = s.high;
			default:               read_reg = s.low;
		endcase
	endfunction : read_reg

	assign rd_data = read_reg(sp_addr, r);

	// ==========================================================
	// Limit comparison
	assign res16 = r.cfg[tclm_pkg::CFG_RES_BIT];
	// In 13-bit format the three low bits are flags, so they never enter a compare
	assign mask = res16 ? 16'hffff : tclm_pkg::MASK13;
	assign samp = temp_sample_in & mask;
	assign t_v = signed'({samp[15], samp});
	assign crit_v = signed'({r.crit[15], r.crit & mask});
	assign high_v = signed'({r.high[15], r.high & mask});
	assign low_v = signed'({r.low[15], r.low & mask});
	assign hyst_v = signed'(17'(r.hyst) << tclm_pkg::HYST_SHIFT);
	assign over_crit = t_v > crit_v;
	assign over_high = t_v > high_v;
	assign under_low = t_v < low_v;
	assign fault = over_crit | over_high | under_low;
	assign in_crit = t_v < (crit_v - hyst_v);
	assign in_high = t_v < (high_v - hyst_v);
	assign in_low = t_v > (low_v + hyst_v);
	assign need = {1'b0, r.cfg[tclm_pkg::CFG_FQ_HI:tclm_pkg::CFG_FQ_LO]} + tclm_pkg::FQ_ONE;
	assign cnt_nxt = !fault ? 3'h0 :
		(r.fault_cnt == tclm_pkg::FQ_MAX) ? r.fault_cnt : r.fault_cnt + tclm_pkg::FQ_ONE;
	assign qual = fault && (cnt_nxt >= need);
	assign conv_done = ((r.st == tclm_pkg::ST_FAST) || (r.st == tclm_pkg::ST_CONV)) &&
		(r.tmr == tclm_pkg::TMR_ONE);
	assign int_mode = r.cfg[tclm_pkg::CFG_INTM_BIT];
	assign cur_mode = tclm_pkg::tclm_mode_e'(r.cfg[tclm_pkg::CFG_MODE_HI:tclm_pkg::CFG_MODE_LO]);
	assign wr_mode = tclm_pkg::tclm_mode_e'(sp_wdata[tclm_pkg::CFG_MODE_HI:tclm_pkg::CFG_MODE_LO]);
	assign mode_wr = sp_wr && (sp_addr == tclm_pkg::ADDR_CONFIG);

	// ==========================================================
	// Next state
	always_comb begin
		n = r;
		flags = '0;
		if (r.tmr != tclm_pkg::TMR_ONE) begin
			n.tmr = r.tmr - tclm_pkg::TMR_ONE;
		end

		// Clears first, so a set in the same cycle wins
		if (sp_rd && (sp_addr == tclm_pkg::ADDR_STATUS)) begin
			n.status[tclm_pkg::ST_CRIT_BIT] = 1'b0;
			n.status[tclm_pkg::ST_HIGH_BIT] = 1'b0;
			n.status[tclm_pkg::ST_LOW_BIT] = 1'b0;
		end
		if (sp_rd && (sp_addr == tclm_pkg::ADDR_TEMP)) begin
			n.status[tclm_pkg::ST_RDY_BIT] = 1'b1;
		end
		if (sp_rd && int_mode) begin
			n.crit_act = 1'b0;
			n.lim_act = 1'b0;
		end

		// Register writes
		if (sp_wr) begin
			case (sp_addr)
				tclm_pkg::ADDR_CONFIG: n.cfg = sp_wdata[7:0];
				tclm_pkg::ADDR_CRIT:   n.crit = sp_wdata;
				tclm_pkg::ADDR_HYST:   n.hyst = sp_wdata[7:0];
				tclm_pkg::ADDR_HIGH:   n.high = sp_wdata;
				tclm_pkg::ADDR_LOW:    n.low = sp_wdata;
				default:               n.cfg = r.cfg;
			endcase
		end

		// Conversion finished: store result, judge limits, pick next phase
		if (conv_done) begin
			n.fault_cnt = cnt_nxt;
			if (in_crit) begin
				n.status[tclm_pkg::ST_CRIT_BIT] = 1'b0;
			end
			if (in_high) begin
				n.status[tclm_pkg::ST_HIGH_BIT] = 1'b0;
			end
			if (in_low) begin
				n.status[tclm_pkg::ST_LOW_BIT] = 1'b0;
			end
			if (qual && over_crit) begin
				n.status[tclm_pkg::ST_CRIT_BIT] = 1'b1;
			end
			if (qual && over_high) begin
				n.status[tclm_pkg::ST_HIGH_BIT] = 1'b1;
			end
			if (qual && under_low) begin
				n.status[tclm_pkg::ST_LOW_BIT] = 1'b1;
			end
			if (!int_mode && in_crit) begin
				n.crit_act = 1'b0;
			end
			if (!int_mode && in_high && in_low) begin
				n.lim_act = 1'b0;
			end
			if (qual && over_crit) begin
				n.crit_act = 1'b1;
			end
			if (qual && (over_high || under_low)) begin
				n.lim_act = 1'b1;
			end
			n.band_crit = in_crit;
			n.band_lim = in_high && in_low;
			flags = {n.status[tclm_pkg::ST_CRIT_BIT], n.status[tclm_pkg::ST_HIGH_BIT],
				n.status[tclm_pkg::ST_LOW_BIT]};
			n.temp = res16 ? samp : {samp[15:3], flags};
			case (cur_mode)
				tclm_pkg::MODE_CONT: begin
					n.st = tclm_pkg::ST_CONV;
					n.tmr = P_CONV_CYC;
				end
				tclm_pkg::MODE_SPS: begin
					n.st = tclm_pkg::ST_IDLE;
					n.tmr = P_SPS_IDLE_CYC;
				end
				default: begin
					n.st = tclm_pkg::ST_SHDN;
				end
			endcase
		end else begin
			case (r.st)
				tclm_pkg::ST_IDLE: begin
					if (r.tmr == tclm_pkg::TMR_ONE) begin
						n.st = tclm_pkg::ST_CONV;
						n.tmr = P_SPS_CONV_CYC;
					end
				end
				tclm_pkg::ST_WAKE: begin
					if (r.tmr == tclm_pkg::TMR_ONE) begin
						n.st = tclm_pkg::ST_CONV;
						n.tmr = (cur_mode == tclm_pkg::MODE_SPS) ? P_SPS_CONV_CYC : P_CONV_CYC;
					end
				end
				default: n.st = r.st;
			endcase
		end

		// Mode write overrides the sequencer
		if (mode_wr) begin
			case (wr_mode)
				tclm_pkg::MODE_SHDN: begin
					n.st = tclm_pkg::ST_SHDN;
				end
				tclm_pkg::MODE_CONT: begin
					if (r.st == tclm_pkg::ST_SHDN) begin
						n.st = tclm_pkg::ST_WAKE;
						n.tmr = P_WAKE_CYC;
					end
				end
				default: begin
					// A result stored in this same cycle decides, so a fresh set is never lost
					if (wr_mode == tclm_pkg::MODE_SINGLE && !int_mode && r.band_lim && !conv_done) begin
						n.lim_act = 1'b0;
					end
					if (wr_mode == tclm_pkg::MODE_SINGLE && !int_mode && r.band_crit && !conv_done) begin
						n.crit_act = 1'b0;
					end
					if (!conv_done) begin
						n.status[tclm_pkg::ST_RDY_BIT] = 1'b1;
					end
					if (r.st == tclm_pkg::ST_SHDN) begin
						n.st = tclm_pkg::ST_WAKE;
						n.tmr = P_WAKE_CYC;
					end else begin
						n.st = tclm_pkg::ST_CONV;
						n.tmr = (wr_mode == tclm_pkg::MODE_SPS) ? P_SPS_CONV_CYC : P_CONV_CYC;
					end
				end
			endcase
		end

		// Store beats a ready-restoring read in the same cycle
		if (conv_done) begin
			n.status[tclm_pkg::ST_RDY_BIT] = 1'b0;
		end

		// Pin drive; polarity bit 0 means active low
		n.crit_pin = n.cfg[tclm_pkg::CFG_CTPOL] ? n.crit_act : ~n.crit_act;
		n.lim_pin = n.cfg[tclm_pkg::CFG_INTPOL] ? n.lim_act : ~n.lim_act;
		n.crit_oe = ~n.crit_pin;
		n.lim_oe = ~n.lim_pin;
		n.mod_en = (n.st == tclm_pkg::ST_FAST) || (n.st == tclm_pkg::ST_CONV);
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			r <= TOP_RST;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign modulator_en_out = r.mod_en;
	assign critical_alarm_out = r.crit_pin;
	assign critical_alarm_oe_out = r.crit_oe;
	assign limit_alarm_out = r.lim_pin;
	assign limit_alarm_oe_out = r.lim_oe;

endmodule : tclm_top

`default_nettype wire

// >>> tclm_pkg.sv
// Shared constants and types of the temperature conversion and limit monitor
package tclm_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ      = 25_000_000;
	localparam int unsigned MS_PER_S    = 1000;
	localparam int unsigned CONV_MS     = 240;
	localparam int unsigned FAST_MS     = 6;
	localparam int unsigned SPS_CONV_MS = 60;
	localparam int unsigned SPS_IDLE_MS = 940;
	localparam int unsigned WAKE_MS     = 1;
	localparam int unsigned TMR_W       = 25;
	localparam logic [TMR_W-1:0] CONV_CYC     = TMR_W'(CLK_HZ / MS_PER_S * CONV_MS);
	localparam logic [TMR_W-1:0] FAST_CYC     = TMR_W'(CLK_HZ / MS_PER_S * FAST_MS);
	localparam logic [TMR_W-1:0] SPS_CONV_CYC = TMR_W'(CLK_HZ / MS_PER_S * SPS_CONV_MS);
	localparam logic [TMR_W-1:0] SPS_IDLE_CYC = TMR_W'(CLK_HZ / MS_PER_S * SPS_IDLE_MS);
	localparam logic [TMR_W-1:0] WAKE_CYC     = TMR_W'(CLK_HZ / MS_PER_S * WAKE_MS);
	localparam logic [TMR_W-1:0] TMR_ONE      = 25'h0000001;

	// ==========================================================
	// Register addresses
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_CONFIG = 3'h1;
	localparam logic [2:0] ADDR_TEMP   = 3'h2;
	localparam logic [2:0] ADDR_ID     = 3'h3;
	localparam logic [2:0] ADDR_CRIT   = 3'h4;
	localparam logic [2:0] ADDR_HYST   = 3'h5;
	localparam logic [2:0] ADDR_HIGH   = 3'h6;
	localparam logic [2:0] ADDR_LOW    = 3'h7;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  RST_STATUS = 8'h80;
	localparam logic [7:0]  RST_CONFIG = 8'h00;
	localparam logic [15:0] RST_TEMP   = 16'h0000;
	localparam logic [15:0] RST_CRIT   = 16'h4980;
	localparam logic [7:0]  RST_HYST   = 8'h05;
	localparam logic [15:0] RST_HIGH   = 16'h2000;
	localparam logic [15:0] RST_LOW    = 16'h0500;
	// Arbitrary neutral identification value
	localparam logic [7:0]  ID_VALUE   = 8'h5a;

	// ==========================================================
	// Field positions
	localparam int unsigned CFG_RES_BIT  = 7;
	localparam int unsigned CFG_MODE_HI  = 6;
	localparam int unsigned CFG_MODE_LO  = 5;
	localparam int unsigned CFG_INTM_BIT = 4;
	localparam int unsigned CFG_CTPOL    = 3;
	localparam int unsigned CFG_INTPOL   = 2;
	localparam int unsigned CFG_FQ_HI    = 1;
	localparam int unsigned CFG_FQ_LO    = 0;
	localparam int unsigned ST_RDY_BIT   = 7;
	localparam int unsigned ST_CRIT_BIT  = 6;
	localparam int unsigned ST_HIGH_BIT  = 5;
	localparam int unsigned ST_LOW_BIT   = 4;
	localparam int unsigned CMD_RD_BIT   = 6;
	localparam int unsigned CMD_ADDR_HI  = 5;
	localparam int unsigned CMD_ADDR_LO  = 3;
	localparam int unsigned HYST_SHIFT   = 7;
	localparam logic [15:0] MASK13       = 16'hfff8;
	localparam logic [3:0]  BYTE_LAST    = 4'h7;
	localparam logic [3:0]  WORD_LAST    = 4'hf;
	localparam logic [2:0]  FQ_MAX       = 3'h4;
	localparam logic [2:0]  FQ_ONE       = 3'h1;

	// ==========================================================
	// Modes and states
	typedef enum logic [1:0] {
		MODE_CONT   = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_SPS    = 2'b10,
		MODE_SHDN   = 2'b11
	} tclm_mode_e;

	typedef enum logic [2:0] {
		ST_FAST = 3'b000,
		ST_CONV = 3'b001,
		ST_IDLE = 3'b010,
		ST_SHDN = 3'b011,
		ST_WAKE = 3'b100
	} tclm_conv_e;

endpackage : tclm_pkg

// >>> tclm_spi.sv
// Serial port front end: pin synchronisers, command decode, shift registers
`timescale 1ns/1ps
`default_nettype none

module tclm_spi (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	// Serial pins
	input  wire logic        sclk_in,
	input  wire logic        cs_b_in,
	input  wire logic        din_in,
	output logic             dout_out,
	output logic             dout_oe_out,
	// Register side
	input  wire logic        addr_wide_in,
	input  wire logic [15:0] rd_data_in,
	output logic [2:0]       addr_out,
	output logic             rd_strobe_out,
	output logic             wr_strobe_out,
	output logic [15:0]      wr_data_out
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [2:0]  sclk_s;
		logic [1:0]  cs_s;
		logic [1:0]  din_s;
		logic        data_ph;
		logic [3:0]  bit_cnt;
		logic [15:0] sh_in;
		logic [15:0] sh_out;
		logic [2:0]  addr;
		logic        rd;
		logic        load_pend;
		logic        wr_stb;
		logic [15:0] wr_data;
		logic        dout;
		logic        dout_oe;
	} tclm_spi_s;

	// Clock idles high, so sync stages start high to avoid a false edge
	localparam tclm_spi_s SPI_RST = '{sclk_s: 3'h7, cs_s: 2'h3, default: '0};

	tclm_spi_s r;
	tclm_spi_s n;
	logic      rise;
	logic      fall;

	assign rise = r.sclk_s[1] & ~r.sclk_s[2];
	assign fall = ~r.sclk_s[1] & r.sclk_s[2];

	// ==========================================================
	// Next state
	always_comb begin
		n = r;
		n.sclk_s = {r.sclk_s[1:0], sclk_in};
		n.cs_s = {r.cs_s[0], cs_b_in};
		n.din_s = {r.din_s[0], din_in};
		n.wr_stb = 1'b0;
		n.load_pend = 1'b0;
		if (r.cs_s[1]) begin
			n.data_ph = 1'b0;
			n.bit_cnt = '0;
			n.rd = 1'b0;
			n.dout_oe = 1'b0;
		end else begin
			n.dout_oe = 1'b1;
			// One-byte registers go out in the upper lane so MSB leads
			if (r.load_pend) begin
				n.sh_out = addr_wide_in ? rd_data_in : {rd_data_in[7:0], 8'h00};
			end
			if (rise) begin
				n.sh_in = {r.sh_in[14:0], r.din_s[1]};
				n.bit_cnt = r.bit_cnt + 4'h1;
				if (!r.data_ph) begin
					if (r.bit_cnt == tclm_pkg::BYTE_LAST) begin
						n.data_ph = 1'b1;
						n.bit_cnt = '0;
						n.addr = n.sh_in[tclm_pkg::CMD_ADDR_HI:tclm_pkg::CMD_ADDR_LO];
						n.rd = n.sh_in[tclm_pkg::CMD_RD_BIT];
						n.load_pend = n.sh_in[tclm_pkg::CMD_RD_BIT];
					end
				end else if (!r.rd && r.bit_cnt == (addr_wide_in ? tclm_pkg::WORD_LAST : tclm_pkg::BYTE_LAST)) begin
					n.wr_stb = 1'b1;
					n.wr_data = addr_wide_in ? n.sh_in : {8'h00, n.sh_in[7:0]};
					n.data_ph = 1'b0;
					n.bit_cnt = '0;
				end
			end
			if (fall && r.data_ph && r.rd) begin
				n.dout = r.sh_out[15];
				n.sh_out = {r.sh_out[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			r <= SPI_RST;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign dout_out = r.dout;
	assign dout_oe_out = r.dout_oe;
	assign addr_out = r.addr;
	assign rd_strobe_out = r.load_pend;
	assign wr_strobe_out = r.wr_stb;
	assign wr_data_out = r.wr_data;

endmodule : tclm_spi

`default_nettype wire

// >>> tclm_checker.sv
// Pin-level assertions of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tclm_checker (
	// Watched pins
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic sclk_in,
	input wire logic cs_b_in,
	input wire logic dout_out,
	input wire logic dout_oe_out,
	input wire logic modulator_en_out,
	input wire logic critical_alarm_out,
	input wire logic critical_alarm_oe_out,
	input wire logic limit_alarm_out,
	input wire logic limit_alarm_oe_out
);
	// =========
	// Pin relations
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	a_reset_alarm: assert property ($rose(rst_b_in) |-> critical_alarm_out && limit_alarm_out)
		else $error("alarm pin active out of reset");
	a_reset_start: assert property ($rose(rst_b_in) |-> modulator_en_out && !dout_oe_out)
		else $error("no conversion at reset release");
	a_crit_drain: assert property (critical_alarm_oe_out == !critical_alarm_out)
		else $error("critical enable disagrees with level");
	a_int_drain: assert property (limit_alarm_oe_out == !limit_alarm_out)
		else $error("limit enable disagrees with level");
	a_oe_idle: assert property (cs_b_in [*5] |-> !dout_oe_out)
		else $error("data out driven while deselected");
	a_oe_busy: assert property (!cs_b_in [*5] |-> dout_oe_out)
		else $error("data out released while selected");
	a_dout_hold: assert property (($stable(sclk_in) && $stable(cs_b_in)) [*5] |-> $stable(dout_out))
		else $error("data out moved without a clock fall");
	// Alarms move only on a conversion result or a register access
	a_alarm_rest: assert property ((!modulator_en_out && cs_b_in) [*5] |->
		$stable(critical_alarm_out) && $stable(limit_alarm_out))
		else $error("alarm moved while idle");
endmodule : tclm_checker
bind tclm_top tclm_checker tclm_checker_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .sclk_in(sclk_in),
	.cs_b_in(cs_b_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out), .modulator_en_out(modulator_en_out),
	.critical_alarm_out(critical_alarm_out), .critical_alarm_oe_out(critical_alarm_oe_out),
	.limit_alarm_out(limit_alarm_out), .limit_alarm_oe_out(limit_alarm_oe_out));
`default_nettype wire

// >>> tclm_host.sv
// Host serial master model of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tclm_host (
	// Clock and device output
	input wire logic mclk_in,
	input wire logic dout_in,
	input wire logic dout_oe_in,
	// Serial pins driven
	output logic     sclk_out,
	output logic     cs_b_out,
	output logic     din_out
);
	// =========
	// Frame engine
	initial begin
		sclk_out = 1'b1;
		cs_b_out = 1'b1;
		din_out = 1'b0;
	end
	// Clock rests high between frames; read data taken at each rise after the command byte
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n, output logic [15:0] rd);
		logic [23:0] sh;
		sh = {cmd, wd};
		rd = 16'h0000;
		@(negedge mclk_in);
		cs_b_out = 1'b0;
		repeat (4) @(negedge mclk_in);
		for (int i = 0; i < 8 + n; i++) begin
			sclk_out = 1'b0;
			din_out = sh[23];
			sh = sh << 1;
			repeat (4) @(negedge mclk_in);
			sclk_out = 1'b1;
			if (i >= 8) rd = {rd[14:0], dout_oe_in ? dout_in : 1'bx};
			repeat (4) @(negedge mclk_in);
		end
		cs_b_out = 1'b1;
		din_out = ~din_out;
		repeat (8) @(negedge mclk_in);
	endtask : xfer
endmodule : tclm_host
`default_nettype wire

// >>> tclm_top_test.sv
// Self-checking bench of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tclm_top_test;
	// =========
	// Pins and bookkeeping
	logic        mclk_in;
	logic        rst_b_in;
	logic        sclk_in;
	logic        cs_b_in;
	logic        din_in;
	logic        dout_out;
	logic        dout_oe_out;
	logic [15:0] temp_sample_in;
	logic        modulator_en_out;
	logic [1:0]  pins;
	int          bad_count;
	int          checked;
	int          cycles;
	logic [15:0] v;
	logic [15:0] shot_t [8];
	logic [1:0]  shot_p [8];
	// Short timings keep the run brief; all waits below follow them
	tclm_top #(.P_CONV_CYC(25'h0000c8), .P_FAST_CYC(25'h0000032), .P_SPS_CONV_CYC(25'h000003c),
		.P_SPS_IDLE_CYC(25'h000012c), .P_WAKE_CYC(25'h0000014)) tclm_top_inst (.mclk_in(mclk_in),
		.rst_b_in(rst_b_in), .sclk_in(sclk_in), .cs_b_in(cs_b_in), .din_in(din_in), .dout_out(dout_out),
		.dout_oe_out(dout_oe_out), .temp_sample_in(temp_sample_in), .modulator_en_out(modulator_en_out),
		.critical_alarm_out(pins[1]), .critical_alarm_oe_out(), .limit_alarm_out(pins[0]), .limit_alarm_oe_out());
	tclm_host tclm_host_inst (.mclk_in(mclk_in), .dout_in(dout_out), .dout_oe_in(dout_oe_out),
		.sclk_out(sclk_in), .cs_b_out(cs_b_in), .din_out(din_in));
	// =========
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rchk(input logic [2:0] a, input int n, input logic [15:0] e);
		tclm_host_inst.xfer({2'b01, a, 3'h0}, 16'h0000, n, v);
		check(v, e);
	endtask : rchk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		tclm_host_inst.xfer({2'b00, a, 3'h0}, {d, 8'h00}, 8, v);
	endtask : wr
	task automatic close_out();
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// =========
	// Clock and hang guard
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end
	// =========
	// Scenarios
	initial begin
		rst_b_in = 1'b0;
		temp_sample_in = 16'h0c80;
		bad_count = 0;
		checked = 0;
		cycles = 0;
		shot_t = '{16'h4b00, 16'h4b00, 16'h0c80, 16'h4b00, 16'h4b00, 16'h4b00, 16'h4b00, 16'h0c80};
		shot_p = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h3};
		repeat (20) @(negedge mclk_in);
		rst_b_in = 1'b1;
		rchk(tclm_pkg::ADDR_TEMP, 16, 16'h0c80);
		rchk(tclm_pkg::ADDR_CRIT, 16, 16'h4980);
		rchk(tclm_pkg::ADDR_HIGH, 16, 16'h2000);
		temp_sample_in = 16'h4b00;
		repeat (420) @(negedge mclk_in);
		check({14'h0, pins}, 16'h0000);
		rchk(tclm_pkg::ADDR_TEMP, 16, 16'h4b06);
		wr(tclm_pkg::ADDR_CONFIG, 8'h0c);
		repeat (220) @(negedge mclk_in);
		check({14'h0, pins}, 16'h0003);
		wr(tclm_pkg::ADDR_CONFIG, 8'h10);
		repeat (220) @(negedge mclk_in);
		temp_sample_in = 16'h0c80;
		repeat (440) @(negedge mclk_in);
		check({14'h0, pins}, 16'h0000);
		rchk(tclm_pkg::ADDR_CONFIG, 8, 16'h0010);
		check({14'h0, pins}, 16'h0003);
		// Single shots with a queue of four, comparator behaviour
		for (int i = 0; i < 8; i++) begin
			wr(tclm_pkg::ADDR_CONFIG, 8'h23);
			// Sample changes after the write, so a leftover continuous conversion never sees it
			temp_sample_in = shot_t[i];
			repeat (260) @(negedge mclk_in);
			check({14'h0, pins}, {14'h0, shot_p[i]});
		end
		check({15'h0, modulator_en_out}, 16'h0000);
		temp_sample_in = 16'h1234;
		rchk(tclm_pkg::ADDR_STATUS, 8, 16'h0000);
		rchk(tclm_pkg::ADDR_TEMP, 16, 16'h0c80);
		rchk(tclm_pkg::ADDR_STATUS, 8, 16'h0080);
		wr(tclm_pkg::ADDR_CONFIG, 8'h80);
		repeat (260) @(negedge mclk_in);
		rchk(tclm_pkg::ADDR_TEMP, 16, 16'h1234);
		check(v >> 7, 16'h0024);
		wr(tclm_pkg::ADDR_CONFIG, 8'he0);
		temp_sample_in = 16'h0c80;
		repeat (260) @(negedge mclk_in);
		check({15'h0, modulator_en_out}, 16'h0000);
		rchk(tclm_pkg::ADDR_TEMP, 16, 16'h1234);
		wr(tclm_pkg::ADDR_CONFIG, 8'h40);
		repeat (150) @(negedge mclk_in);
		check({15'h0, modulator_en_out}, 16'h0000);
		repeat (250) @(negedge mclk_in);
		check({15'h0, modulator_en_out}, 16'h0001);
		close_out();
	end
endmodule : tclm_top_test
`default_nettype wire
